/* File: shared/mqw_consts.svh */
// Constants of the multi-queue write port: address fields, widths, resets.
// Assumes inclusion by the package and the design file only.
`ifndef MQW_CONSTS_SVH
`define MQW_CONSTS_SVH
`define MQW_ADDR_W 8
`define MQW_DATA_W 18
`define MQW_QUEUE_MSB 4
`define MQW_QUEUE_LSB 0
`define MQW_ID_MSB 7
`define MQW_ID_LSB 5
`define MQW_QUAD_MSB 1
`define MQW_QUAD_LSB 0
`define MQW_QUEUE_RST 5'h00
`define MQW_QUAD_RST 2'h0
`define MQW_QUAD_STEP 2'h1
`endif

/* File: shared/mqw_pkg.sv */
// Types shared by the multi-queue write port and its surroundings.
// Assumes the constants header lies on the include path.
`include "mqw_consts.svh"
package mqw_pkg;
	// Control pins of the write-side controller, sampled each enabled edge.
	typedef struct packed {
		logic [`MQW_ADDR_W-1:0] write_queue_address;
		logic write_address_strobe;
		logic flag_quadrant_strobe;
		logic write_enable_n;
	} mqw_ctrl_t;
	// One accepted write: destination queue and the data word.
	typedef struct packed {
		logic [`MQW_QUEUE_MSB:`MQW_QUEUE_LSB] queue;
		logic [`MQW_DATA_W-1:0] data;
	} mqw_word_t;
	// Selection pipeline stage: queue chosen and whether this device answered.
	typedef struct packed {
		logic valid;
		logic match;
		logic [`MQW_QUEUE_MSB:`MQW_QUEUE_LSB] queue;
	} mqw_pend_t;
endpackage

/* File: rtl/mqw_write_port.sv */
// Write-port queue selection for a 32-queue flow-control memory.
// Assumes synchronous inputs on sys_clk and a memory that drains words
// through a valid/ready pair.
//
// Contract
// (R1) A word is written on an edge only while the active-low enable is low.
// (R2) Queue selection is taken on an edge whatever the write enable level.
// (R3) Selection edge and next edge write old queue; new queue two edges on.
// (R4) Flag bus steps when polled, quadrant taken when direct, no enable.
// (R5) Address is 8 bits; low five bits pick one of 32 queues.
// (R6) High three bits pick a cascaded device; only matching identity acts.
// (R7) Address captured as new queue on an edge with the address strobe high.
// (R8) Quadrant select uses address bits 1..0; bits 4..2 are ignored.
// (R9) Quadrant latched on flag strobe edge; same-edge write uses old queue.
// (R10) Quadrant select also needs the high bits to match the identity.
// (R11) Controller never raises both strobes at once nor holds address strobe.
// (R12) Controller selects no queue before serial programming has finished.
// (R13) Controller supplies a continuous free-running write clock.
// (R14) After reset no queue is selected and write enables are ignored.
// (R15) A foreign selection keeps old selections and blocks writes meanwhile.
`timescale 1ns/1ns
`include "mqw_consts.svh"

module mqw_write_port (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [`MQW_ID_MSB-`MQW_ID_LSB:0] device_id,
	input wire logic polled_mode,
	input wire mqw_pkg::mqw_ctrl_t write_ctrl,
	input wire logic [`MQW_DATA_W-1:0] data_in,
	output logic write_space,
	output mqw_pkg::mqw_word_t write_word,
	output logic write_valid,
	input wire logic write_ready,
	output logic [`MQW_QUAD_MSB:`MQW_QUAD_LSB] flag_quadrant,
	output logic queue_selected
);
	import mqw_pkg::*;

	// ************************************************************
	// Address decode
	// ************************************************************

	logic id_match;
	logic [`MQW_QUEUE_MSB:`MQW_QUEUE_LSB] addr_queue;
	logic [`MQW_QUAD_MSB:`MQW_QUAD_LSB] addr_quad;

	// Split the address bus into identity, queue and quadrant fields.
	always_comb begin
		id_match = (write_ctrl.write_queue_address[`MQW_ID_MSB:`MQW_ID_LSB]
			== device_id); // [R6] [R10]
		addr_queue = write_ctrl.write_queue_address[`MQW_QUEUE_MSB:
			`MQW_QUEUE_LSB]; // [R5]
		addr_quad = write_ctrl.write_queue_address[`MQW_QUAD_MSB:
			`MQW_QUAD_LSB]; // [R8]
	end

	// ************************************************************
	// Queue selection pipeline
	// ************************************************************

	mqw_pend_t pend;
	mqw_pend_t next_pend;
	logic [`MQW_QUEUE_MSB:`MQW_QUEUE_LSB] cur_queue;
	logic [`MQW_QUEUE_MSB:`MQW_QUEUE_LSB] next_cur_queue;
	logic sel_valid;
	logic next_sel_valid;
	logic selected;
	logic next_selected;

	// A strobed address waits one edge in pend, then becomes current, so
	// writes on the strobe edge and the next still use the old queue.
	always_comb begin
		next_pend = pend;
		next_pend.valid = 1'b0;
		next_cur_queue = cur_queue;
		next_sel_valid = sel_valid;
		next_selected = selected;
		if (pend.valid) begin
			next_selected = pend.match; // [R15]
			if (pend.match) begin
				next_cur_queue = pend.queue; // [R3]
				next_sel_valid = 1'b1;
			end
		end
		if (write_ctrl.write_address_strobe) begin // [R2] [R7]
			next_pend.valid = 1'b1;
			next_pend.match = id_match; // [R6]
			next_pend.queue = addr_queue; // [R5]
		end
	end

	// Register the selection state; reset leaves no queue chosen.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pend <= '0;
			cur_queue <= `MQW_QUEUE_RST;
			sel_valid <= 1'b0; // [R14]
			selected <= 1'b0;
			queue_selected <= 1'b0;
		end else if (clk_en) begin
			pend <= next_pend;
			cur_queue <= next_cur_queue;
			sel_valid <= next_sel_valid;
			selected <= next_selected;
			queue_selected <= next_sel_valid & next_selected;
		end
	end

	// ************************************************************
	// Flag quadrant select
	// ************************************************************

	logic [`MQW_QUAD_MSB:`MQW_QUAD_LSB] next_quad;

	// Polled mode steps the quadrant every enabled edge; direct mode takes it from
	// the flag strobe. Neither looks at the write enable.
	always_comb begin
		next_quad = flag_quadrant;
		if (polled_mode) begin
			next_quad = flag_quadrant + `MQW_QUAD_STEP; // [R4]
		end else if (write_ctrl.flag_quadrant_strobe && id_match) begin
			next_quad = addr_quad; // [R4] [R8] [R9] [R10]
		end
	end

	// Register the quadrant shown on the almost-full flag bus.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			flag_quadrant <= `MQW_QUAD_RST;
		end else if (clk_en) begin
			flag_quadrant <= next_quad;
		end
	end

	// ************************************************************
	// Write acceptance
	// ************************************************************

	logic push;
	mqw_word_t in_word;

	// Accept a word only with the enable low, a queue held and room left.
	always_comb begin
		push = !write_ctrl.write_enable_n && sel_valid && selected
			&& write_space; // [R1] [R14] [R15]
		in_word.queue = cur_queue; // [R3] [R9]
		in_word.data = data_in;
	end

	// ************************************************************
	// Two-entry buffer
	// ************************************************************

	mqw_word_t skid_word;
	mqw_word_t next_skid_word;
	mqw_word_t next_out_word;
	logic skid_valid;
	logic next_skid_valid;
	logic next_out_valid;
	logic next_space;
	logic out_free;

	// The output stage refills from the skid entry first, then from the
	// input; a stalled output parks the incoming word in the skid entry.
	always_comb begin
		out_free = !write_valid || write_ready;
		next_out_word = write_word;
		next_out_valid = write_valid;
		next_skid_word = skid_word;
		next_skid_valid = skid_valid;
		if (out_free) begin
			if (skid_valid) begin
				next_out_word = skid_word;
				next_out_valid = 1'b1;
				next_skid_valid = push;
				next_skid_word = in_word;
			end else begin
				next_out_word = in_word;
				next_out_valid = push;
			end
		end else if (push) begin
			next_skid_word = in_word;
			next_skid_valid = 1'b1;
		end
		next_space = !next_skid_valid;
	end

	// Register the buffer; space is offered again once the skid drains.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			write_word <= '0;
			write_valid <= 1'b0;
			skid_word <= '0;
			skid_valid <= 1'b0;
			write_space <= 1'b1;
		end else if (clk_en) begin
			write_word <= next_out_word;
			write_valid <= next_out_valid;
			skid_word <= next_skid_word;
			skid_valid <= next_skid_valid;
			write_space <= next_space;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************

	// An idle output stays idle unless an enabled write arrives; the skid
	// entry only fills behind a valid output, so this sees every push.
	a_enable_gates_write: assert property ( // [R1]
		@(posedge sys_clk) disable iff (rst)
		(write_ctrl.write_enable_n && !write_valid) |=> !write_valid)
		else $error("write taken with enable high");

	// Strobe is taken even with the write enable high.
	a_select_any_enable: assert property ( // [R2]
		@(posedge sys_clk) disable iff (rst)
		(clk_en && write_ctrl.write_address_strobe
			&& write_ctrl.write_enable_n) |=> pend.valid)
		else $error("selection lost while enable high");

	// Queue stays old on the edge after the strobe.
	a_old_queue_kept: assert property ( // [R3]
		@(posedge sys_clk) disable iff (rst)
		(clk_en && write_ctrl.write_address_strobe && !pend.valid)
			|=> cur_queue == $past(cur_queue))
		else $error("queue changed one edge early");

	// New queue is current two edges after a matching strobe.
	a_new_queue_late: assert property ( // [R3] [R5] [R7]
		@(posedge sys_clk) disable iff (rst)
		(clk_en && write_ctrl.write_address_strobe && id_match)
			##1 (clk_en && !write_ctrl.write_address_strobe)
			|=> (cur_queue == $past(addr_queue, 2)) && sel_valid
			&& selected)
		else $error("new queue not current after two edges");

	// Other identity deselects the device and keeps its queue; a strobe
	// just before it may still land, so compare with one edge back.
	a_other_id_stops: assert property ( // [R6] [R15]
		@(posedge sys_clk) disable iff (rst)
		(clk_en && write_ctrl.write_address_strobe && !id_match)
			##1 (clk_en && !write_ctrl.write_address_strobe)
			|=> !selected && cur_queue == $past(cur_queue)
			&& !push)
		else $error("foreign selection acted on");

	// Without a held selection no word reaches an idle output.
	a_idle_after_reset: assert property ( // [R14]
		@(posedge sys_clk) disable iff (rst)
		(!queue_selected && !write_valid) |=> !write_valid)
		else $error("write taken before a queue was chosen");

	// Direct mode latches quadrant from address bits 1..0.
	a_quad_latch: assert property ( // [R8] [R9]
		@(posedge sys_clk) disable iff (rst)
		(clk_en && !polled_mode && write_ctrl.flag_quadrant_strobe
			&& id_match) |=> flag_quadrant == $past(addr_quad))
		else $error("quadrant not latched");

	// Quadrant ignores a strobe for another device.
	a_quad_foreign: assert property ( // [R10] [R15]
		@(posedge sys_clk) disable iff (rst)
		(clk_en && !polled_mode && write_ctrl.flag_quadrant_strobe
			&& !id_match) |=> $stable(flag_quadrant))
		else $error("quadrant moved for another device");

	// Polled mode steps the quadrant on every enabled edge.
	a_poll_step: assert property ( // [R4]
		@(posedge sys_clk) disable iff (rst)
		(clk_en && polled_mode) |=> flag_quadrant
			== 2'($past(flag_quadrant) + `MQW_QUAD_STEP))
		else $error("polled quadrant did not step");

	// A stalled output word holds still.
	a_buffer_holds: assert property ( // [R1]
		@(posedge sys_clk) disable iff (rst)
		(write_valid && !write_ready) |=> write_valid
			&& $stable(write_word))
		else $error("stalled word lost");
endmodule

/* File: test/mqw_sink_model.sv */
// Sink model of the queue memory that drains the write port.
// Assumes the port's valid/ready pair on sys_clk.
`timescale 1ns/1ns
module mqw_sink_model (
	input wire logic sys_clk,
	input wire logic stall,
	input wire mqw_pkg::mqw_word_t write_word,
	input wire logic write_valid,
	output logic write_ready = 1'b0
);
	import mqw_pkg::*;
	mqw_word_t got[$];
	// Ready follows the stall request just after each edge.
	always @(posedge sys_clk) begin
		write_ready <= #1 !stall;
		if (write_valid && write_ready) begin
			got.push_back(write_word);
		end
	end
endmodule

/* File: test/testbench.sv */
// Self-checking bench of the write-port queue selection.
// Assumes the design and the sink model are compiled first.
`timescale 1ns/1ns
module testbench;
	import mqw_pkg::*;
	localparam logic [2:0] OWN_ID = 3'h2;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	logic [2:0] device_id = OWN_ID;
	logic polled_mode = 1'b0;
	mqw_ctrl_t ctrl = '{8'h00, 1'b0, 1'b0, 1'b1};
	logic [17:0] data_in = 18'h00000;
	logic stall = 1'b0;
	logic write_space, write_valid, write_ready, queue_selected;
	mqw_word_t write_word;
	logic [1:0] flag_quadrant;
	int bad_count = 0;
	int comparisons = 0;
	int cycles = 0;

	// ****
	// Clock, design and sink.
	// ****
	// Free-running clock, never stopped.
	always #5 sys_clk = ~sys_clk;
	mqw_write_port i_mqw_write_port (.sys_clk(sys_clk), .rst(rst),
		.clk_en(clk_en), .device_id(device_id), .polled_mode(polled_mode),
		.write_ctrl(ctrl), .data_in(data_in), .write_space(write_space),
		.write_word(write_word), .write_valid(write_valid),
		.write_ready(write_ready), .flag_quadrant(flag_quadrant),
		.queue_selected(queue_selected));
	mqw_sink_model i_mqw_sink_model (.sys_clk(sys_clk), .stall(stall),
		.write_word(write_word), .write_valid(write_valid),
		.write_ready(write_ready));

	// ****
	// Shared tasks.
	// ****
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Drives one cycle of controller pins; never both strobes at once.
	task automatic cyc(logic [7:0] a, logic as, logic fs, logic wn,
		logic [17:0] d);
		ctrl = '{a, as, fs, wn};
		data_in = d;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic idle(int n);
		repeat (n) cyc(8'h00, 1'b0, 1'b0, 1'b1, 18'h00000);
	endtask
	task automatic word(int i, logic [4:0] q, logic [17:0] d);
		check("word_queue", i_mqw_sink_model.got[i].queue, q);
		check("word_data", i_mqw_sink_model.got[i].data, d);
	endtask
	function automatic int n_words();
		return i_mqw_sink_model.got.size();
	endfunction

	// ****
	// Scenarios.
	// ****
	task automatic t_reset;
		cyc(8'h00, 1'b0, 1'b0, 1'b0, 18'h00011);
		idle(3);
		check("sel_reset", queue_selected, 1'b0);
		check("words_reset", n_words(), 0);
		check("quad_reset", flag_quadrant, 2'h0);
		$display("test reset done");
	endtask
	task automatic t_latency;
		cyc({OWN_ID, 5'h03}, 1'b1, 1'b0, 1'b1, 18'h0);
		idle(2);
		cyc({OWN_ID, 5'h1f}, 1'b1, 1'b0, 1'b0, 18'h00001);
		cyc(8'h00, 1'b0, 1'b0, 1'b0, 18'h00002);
		cyc(8'h00, 1'b0, 1'b0, 1'b0, 18'h00003);
		idle(4);
		check("sel", queue_selected, 1'b1);
		check("words", n_words(), 3);
		word(0, 5'h03, 18'h00001);
		word(1, 5'h03, 18'h00002);
		word(2, 5'h1f, 18'h00003);
		$display("test latency done");
	endtask
	task automatic t_quad;
		logic [1:0] q;
		i_mqw_sink_model.got.delete();
		cyc({OWN_ID, 5'h16}, 1'b0, 1'b1, 1'b0, 18'h00007);
		check("quad", flag_quadrant, 2'h2);
		cyc({3'h5, 5'h01}, 1'b0, 1'b1, 1'b1, 18'h0);
		check("quad_other", flag_quadrant, 2'h2);
		idle(3);
		word(0, 5'h1f, 18'h00007);
		polled_mode = 1'b1;
		q = flag_quadrant;
		idle(1);
		check("polled", flag_quadrant, 2'(q + 2'h1));
		clk_en = 1'b0;
		q = flag_quadrant;
		idle(1);
		check("frozen", flag_quadrant, q);
		clk_en = 1'b1;
		polled_mode = 1'b0;
		$display("test quadrant done");
	endtask
	task automatic t_other;
		i_mqw_sink_model.got.delete();
		cyc({3'h5, 5'h07}, 1'b1, 1'b0, 1'b1, 18'h0);
		idle(2);
		check("sel_other", queue_selected, 1'b0);
		cyc(8'h00, 1'b0, 1'b0, 1'b0, 18'h00009);
		idle(3);
		check("words_other", n_words(), 0);
		cyc({OWN_ID, 5'h0a}, 1'b1, 1'b0, 1'b1, 18'h0);
		idle(2);
		check("sel_back", queue_selected, 1'b1);
		$display("test other device done");
	endtask
	task automatic t_stall;
		int n;
		n = 0;
		stall = 1'b1;
		idle(2);
		for (int i = 0; i < 8; i++) begin
			if (write_space === 1'b1) begin
				cyc(8'h00, 1'b0, 1'b0, 1'b0, 18'(i + 16));
				n++;
			end else begin
				idle(1);
			end
		end
		check("space_full", write_space, 1'b0);
		stall = 1'b0;
		idle(10);
		check("words_stall", n_words(), n);
		for (int i = 0; i < n; i++) begin
			word(i, 5'h0a, 18'(i + 16));
		end
		$display("test stall done");
	endtask

	// ****
	// Run control.
	// ****
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Cuts a hang short well beyond the 57 or so cycles needed.
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			bad_count++;
			print_verdict;
		end
	end
	// Main sequence: reset for six cycles, then each scenario.
	initial begin
		repeat (6) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		t_reset;
		t_latency;
		t_quad;
		t_other;
		t_stall;
		print_verdict;
	end
endmodule
